// ===== rtl/ufc_pkg.sv
// constants and types of the usb frame timing counters
package ufc_pkg;
  localparam logic [7:0] OFS_FRAME_LENGTH = 8'h34;
  localparam logic [7:0] OFS_BITS_LEFT = 8'h38;
  localparam logic [7:0] OFS_FRAME_COUNT = 8'h3c;
  localparam int TOGGLE_POS = 31;
  localparam int MAXPKT_LSB = 16;
  localparam int MAXPKT_MSB = 30;
  localparam logic [13:0] FRAME_LENGTH_RST = 14'h2edf;
  localparam logic [14:0] MAXPKT_RST = 15'h0000;
  localparam logic [13:0] BITS_LEFT_RST = 14'h0000;
  localparam logic [15:0] FRAME_COUNT_RST = 16'h0000;
  localparam logic [15:0] FRAME_COUNT_STEP = 16'h0001;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_SOF = 3'b010,
    WR_STORE = 3'b100
  } ufc_wr_state_t;
endpackage

// ===== rtl/ufc_host_comm_area_if.sv
// boundary request from the counters to the comm area writer
`timescale 1ns/1ps
interface ufc_host_comm_area_if;
  logic start;
  logic [15:0] number;
  modport ctl (output start, output number);
  modport wr (input start, input number);
endinterface // ufc_host_comm_area_if

// ===== rtl/ufc_host_comm_area_writer.sv
// frame boundary sequencer: sof, comm area store, flag
`timescale 1ns/1ps
module ufc_host_comm_area_writer (
  input wire logic clk,
  input wire logic nrst,
  ufc_host_comm_area_if.wr hif,
  input wire logic host_comm_area_ack,
  output logic host_comm_area_req,
  output logic [15:0] host_comm_area_data,
  output logic sof_pulse,
  output logic frame_start_set,
  output logic first_fetch_ok
);
  ufc_pkg::ufc_wr_state_t state_q, state_d;
  logic req_q, req_d, sof_q, sof_d, flag_q, flag_d, fetch_q, fetch_d;
  logic [15:0] data_q, data_d;

  always_comb begin
    state_d = state_q;
    req_d = req_q;
    data_d = data_q;
    fetch_d = fetch_q;
    sof_d = 1'b0;
    flag_d = 1'b0;
    unique case (state_q)
      ufc_pkg::WR_IDLE: begin
        // a boundary while busy is dropped
        if (hif.start) begin
          state_d = ufc_pkg::WR_SOF;
          data_d = hif.number;
          sof_d = 1'b1;
          fetch_d = 1'b0;
        end
      end
      ufc_pkg::WR_SOF: begin
        state_d = ufc_pkg::WR_STORE;
        req_d = 1'b1;
      end
      ufc_pkg::WR_STORE: begin
        if (host_comm_area_ack) begin
          state_d = ufc_pkg::WR_IDLE;
          req_d = 1'b0;
          flag_d = 1'b1;
          fetch_d = 1'b1;
        end
      end
      default: begin
        state_d = ufc_pkg::WR_IDLE;
        req_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ufc_pkg::WR_IDLE;
      req_q <= 1'b0;
      data_q <= ufc_pkg::FRAME_COUNT_RST;
      sof_q <= 1'b0;
      flag_q <= 1'b0;
      fetch_q <= 1'b0;
    end else begin
      state_q <= state_d;
      req_q <= req_d;
      data_q <= data_d;
      sof_q <= sof_d;
      flag_q <= flag_d;
      fetch_q <= fetch_d;
    end
  end

  assign host_comm_area_req = req_q;
  assign host_comm_area_data = data_q;
  assign sof_pulse = sof_q;
  assign frame_start_set = flag_q;
  assign first_fetch_ok = fetch_q;

  a_store_after_sof: assert property (
    @(posedge clk) disable iff (!nrst)
    $rose(req_q) |-> $past(sof_q))
    else $error("store request without preceding sof");
  a_no_fetch_during: assert property (
    @(posedge clk) disable iff (!nrst)
    req_q |-> !fetch_q)
    else $error("descriptor fetch allowed before store");
  a_flag_after_store: assert property (
    @(posedge clk) disable iff (!nrst)
    req_q && host_comm_area_ack |=> flag_q && !req_q && fetch_q)
    else $error("frame start flag not set after store");
  a_flag_only_store: assert property (
    @(posedge clk) disable iff (!nrst)
    flag_q |-> $past(req_q) && $past(host_comm_area_ack))
    else $error("frame start flag without store");
  c_store_done: cover property (
    @(posedge clk) disable iff (!nrst) req_q && host_comm_area_ack);
endmodule // ufc_host_comm_area_writer

// ===== rtl/ufc_frame_timer.sv
// frame bits-left and frame count registers with boundary sequencing
`timescale 1ns/1ps
module ufc_frame_timer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic bit_tick,
  input wire logic run_state,
  input wire logic run_enter,
  input wire logic mem_sel,
  input wire logic mem_wr,
  input wire logic [7:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic host_comm_area_ack,
  output logic [31:0] mem_rdata,
  output logic mem_rvalid,
  output logic host_comm_area_req,
  output logic [15:0] host_comm_area_data,
  output logic sof_pulse,
  output logic frame_start_set,
  output logic first_fetch_ok
);
  logic [13:0] length_q, length_d;
  logic length_tgl_q, length_tgl_d;
  logic [14:0] maxpkt_q, maxpkt_d;
  logic [13:0] left_q, left_d;
  logic left_tgl_q, left_tgl_d;
  logic [15:0] count_q, count_d;
  logic start_q, start_d;
  logic [31:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic wr_length, wr_left, wr_count, rd_any;
  logic frame_end, reload_ev;

  ufc_host_comm_area_if hif ();

  assign rd_any = mem_sel && !mem_wr;
  assign wr_length = mem_sel && mem_wr &&
                     (mem_addr == ufc_pkg::OFS_FRAME_LENGTH);
  assign wr_left = mem_sel && mem_wr &&
                   (mem_addr == ufc_pkg::OFS_BITS_LEFT);
  assign wr_count = mem_sel && mem_wr &&
                    (mem_addr == ufc_pkg::OFS_FRAME_COUNT);
  assign frame_end = run_state && bit_tick && (left_q == 14'h0000);
  assign reload_ev = run_enter || frame_end;

  // frame length register, length read at each reload, toggle only at a frame end reload
  always_comb begin
    length_d = length_q;
    length_tgl_d = length_tgl_q;
    maxpkt_d = maxpkt_q;
    if (wr_length) begin
      length_d = mem_wdata[13:0];
      length_tgl_d = mem_wdata[ufc_pkg::TOGGLE_POS];
      maxpkt_d = mem_wdata[ufc_pkg::MAXPKT_MSB:ufc_pkg::MAXPKT_LSB];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      length_q <= ufc_pkg::FRAME_LENGTH_RST;
      length_tgl_q <= 1'b0;
      maxpkt_q <= ufc_pkg::MAXPKT_RST;
    end else begin
      length_q <= length_d;
      length_tgl_q <= length_tgl_d;
      maxpkt_q <= maxpkt_d;
    end
  end

  // bits-left counter, toggle and frame count
  always_comb begin
    left_d = left_q;
    left_tgl_d = left_tgl_q;
    count_d = count_q;
    start_d = reload_ev;
    if (wr_left) begin
      left_d = mem_wdata[13:0];
      left_tgl_d = mem_wdata[ufc_pkg::TOGGLE_POS];
    end else if (reload_ev) begin
      left_d = length_q;
      if (frame_end) begin
        left_tgl_d = length_tgl_q;
      end
    end else if (run_state && bit_tick) begin
      left_d = left_q - 14'h0001;
    end
    if (wr_count) begin
      count_d = mem_wdata[15:0];
    end else if (reload_ev) begin
      // natural 16-bit wrap from ffff to 0
      count_d = count_q + ufc_pkg::FRAME_COUNT_STEP;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      left_q <= ufc_pkg::BITS_LEFT_RST;
      left_tgl_q <= 1'b0;
      count_q <= ufc_pkg::FRAME_COUNT_RST;
      start_q <= 1'b0;
    end else begin
      left_q <= left_d;
      left_tgl_q <= left_tgl_d;
      count_q <= count_d;
      start_q <= start_d;
    end
  end

  // boundary handed over one cycle later, count already advanced
  assign hif.start = start_q;
  assign hif.number = count_q;

  ufc_host_comm_area_writer u_writer (
    .clk(clk),
    .nrst(nrst),
    .hif(hif),
    .host_comm_area_ack(host_comm_area_ack),
    .host_comm_area_req(host_comm_area_req),
    .host_comm_area_data(host_comm_area_data),
    .sof_pulse(sof_pulse),
    .frame_start_set(frame_start_set),
    .first_fetch_ok(first_fetch_ok)
  );

  // register read port, reserved bits read zero
  always_comb begin
    rdata_d = ufc_pkg::RDATA_RST;
    rvalid_d = rd_any;
    if (rd_any) begin
      unique case (mem_addr)
        ufc_pkg::OFS_FRAME_LENGTH:
          rdata_d = {length_tgl_q, maxpkt_q, 2'h0, length_q};
        ufc_pkg::OFS_BITS_LEFT:
          rdata_d = {left_tgl_q, 17'h0_0000, left_q};
        ufc_pkg::OFS_FRAME_COUNT:
          rdata_d = {16'h0000, count_q};
        default:
          rdata_d = ufc_pkg::RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= ufc_pkg::RDATA_RST;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign mem_rdata = rdata_q;
  assign mem_rvalid = rvalid_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_left_readback: assert property (
    rd_any && mem_addr == ufc_pkg::OFS_BITS_LEFT |=>
    mem_rvalid && mem_rdata[13:0] == $past(left_q) &&
    mem_rdata[31] == $past(left_tgl_q) && mem_rdata[30:14] == 17'h0_0000)
    else $error("bits left read back wrong");
  a_tick_decrement: assert property (
    run_state && bit_tick && !run_enter && !wr_left &&
    left_q != 14'h0000 |=> left_q == $past(left_q) - 14'h0001)
    else $error("bits left did not decrement");
  a_hold_no_tick: assert property (
    !bit_tick && !run_enter && !wr_left |=> $stable(left_q))
    else $error("bits left moved without tick");
  a_zero_reload: assert property (
    frame_end && !wr_left |=> left_q == $past(length_q))
    else $error("bits left not reloaded at zero");
  a_toggle_copy: assert property (
    frame_end && !wr_left |=> left_tgl_q == $past(length_tgl_q))
    else $error("left toggle not copied");
  a_run_reload: assert property (
    run_enter && !wr_left |=> left_q == $past(length_q))
    else $error("bits left not reloaded on run entry");
  a_count_step: assert property (
    frame_end && !wr_count |=>
    count_q == $past(count_q) + ufc_pkg::FRAME_COUNT_STEP)
    else $error("frame count not advanced at reload");
  a_count_wrap: assert property (
    reload_ev && !wr_count && count_q == 16'hffff |=>
    count_q == 16'h0000)
    else $error("frame count did not wrap");
  a_run_count: assert property (
    run_enter && !wr_count |=>
    count_q == $past(count_q) + ufc_pkg::FRAME_COUNT_STEP)
    else $error("frame count not advanced on run entry");
  a_store_number: assert property (
    start_q && !host_comm_area_req && !sof_pulse |=> ##1
    host_comm_area_req && host_comm_area_data == $past(count_q, 2))
    else $error("comm area store not following boundary");
  a_count_readback: assert property (
    rd_any && mem_addr == ufc_pkg::OFS_FRAME_COUNT |=>
    mem_rdata == {16'h0000, $past(count_q)})
    else $error("frame count read back wrong");

  c_frame_end: cover property (frame_end);
  c_count_wrap: cover property (reload_ev && count_q == 16'hffff);
  c_run_enter: cover property (run_enter ##1 start_q);
  c_flag_set: cover property (frame_end ##[1:8] frame_start_set);
endmodule // ufc_frame_timer

// ===== verif/ufc_host_comm_area_mem.sv
// comm area memory model answering frame count stores
`timescale 1ns/1ps
module ufc_host_comm_area_mem (
  input wire logic clk,
  input wire logic nrst,
  input wire logic host_comm_area_req,
  input wire logic [3:0] delay,
  output logic host_comm_area_ack
);
  logic [3:0] cnt_q;
  // ack after a chosen wait, one pulse per store
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 4'h0;
      host_comm_area_ack <= 1'b0;
    end else if (host_comm_area_req && !host_comm_area_ack) begin
      if (cnt_q == delay) begin
        host_comm_area_ack <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end else begin
      host_comm_area_ack <= 1'b0;
      cnt_q <= 4'h0;
    end
  end
endmodule // ufc_host_comm_area_mem

// ===== verif/test_usb_frame_timing_counters.sv
// self-checking bench of the frame timing counters
`timescale 1ns/1ps
module test_usb_frame_timing_counters;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic bit_tick = 1'b0;
  logic run_state = 1'b0;
  logic run_enter = 1'b0;
  logic mem_sel = 1'b0;
  logic mem_wr = 1'b0;
  logic [7:0] mem_addr = 8'h00;
  logic [31:0] mem_wdata = 32'h0000_0000;
  logic [3:0] ack_delay = 4'h0;
  logic host_comm_area_ack, mem_rvalid, host_comm_area_req, sof_pulse, frame_start_set;
  logic first_fetch_ok;
  logic [31:0] mem_rdata, r;
  logic [15:0] host_comm_area_data;
  logic [31:0] rd_q[$];
  logic [15:0] st_q[$];
  int num_errors = 0;
  int n_checks = 0;
  logic sof_seen = 1'b0;
  always #12.5 clk = ~clk;
  ufc_frame_timer ufc_frame_timer_inst (.clk(clk), .nrst(nrst),
    .bit_tick(bit_tick), .run_state(run_state), .run_enter(run_enter),
    .mem_sel(mem_sel), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .host_comm_area_ack(host_comm_area_ack), .mem_rdata(mem_rdata),
    .mem_rvalid(mem_rvalid), .host_comm_area_req(host_comm_area_req), .host_comm_area_data(host_comm_area_data),
    .sof_pulse(sof_pulse), .frame_start_set(frame_start_set),
    .first_fetch_ok(first_fetch_ok));
  ufc_host_comm_area_mem ufc_host_comm_area_mem_inst (.clk(clk), .nrst(nrst),
    .host_comm_area_req(host_comm_area_req), .delay(ack_delay), .host_comm_area_ack(host_comm_area_ack));
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    mem_sel = 1'b1;
    mem_wr = w;
    mem_addr = a;
    mem_wdata = d;
    if (!w) rd_q.push_back(d);
    step();
    mem_sel = 1'b0;
    step();
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      bit_tick = 1'b1;
      step();
      bit_tick = 1'b0;
      repeat (1 + $urandom % 3) step();
    end
  endtask
  task automatic wait_store();
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      if (frame_start_set === 1'b1) break;
    end
    chk("frame start flag", {31'h0, frame_start_set}, 32'h1);
    chk("fetch allowed", {31'h0, first_fetch_ok}, 32'h1);
    step();
  endtask
  // read results and stores taken off the queues as they appear
  always @(negedge clk) begin
    if (sof_pulse === 1'b1) sof_seen = 1'b1;
    if (mem_rvalid === 1'b1) begin
      if (rd_q.size() == 0) chk("read without request", 32'h1, 32'h0);
      else chk("read data", mem_rdata, rd_q.pop_front());
    end
    if (host_comm_area_req === 1'b1 && host_comm_area_ack === 1'b1) begin
      chk("sof before store", {31'h0, sof_seen}, 32'h1);
      sof_seen = 1'b0;
      chk("fetch held", {31'h0, first_fetch_ok}, 32'h0);
      chk("stored count", 32'(host_comm_area_data), 32'(st_q.pop_front()));
    end
  end
  initial begin
    #(25 * 4000);
    num_errors++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h5225));
    repeat (16) @(posedge clk);
    #1 nrst = 1'b1;
    step();
    acc(1'b0, 8'h34, 32'h0000_2edf);
    acc(1'b0, 8'h38, 32'h0000_0000);
    acc(1'b0, 8'h40, 32'h0000_0000);
    ack_delay = 4'($urandom % 6);
    acc(1'b1, 8'h34, 32'h8000_0005);
    st_q.push_back(16'h0001);
    run_enter = 1'b1;
    run_state = 1'b1;
    step();
    run_enter = 1'b0;
    wait_store();
    acc(1'b0, 8'h38, 32'h0000_0005);
    acc(1'b0, 8'h3c, 32'h0000_0001);
    ticks(3);
    acc(1'b0, 8'h38, 32'h0000_0002);
    ticks(2);
    acc(1'b0, 8'h38, 32'h0000_0000);
    st_q.push_back(16'h0002);
    ticks(1);
    wait_store();
    acc(1'b0, 8'h38, 32'h8000_0005);
    acc(1'b0, 8'h3c, 32'h0000_0002);
    acc(1'b1, 8'h34, 32'h0000_0007);
    acc(1'b0, 8'h38, 32'h8000_0005);
    r = {16'h0000, 16'($urandom)};
    acc(1'b1, 8'h3c, r);
    acc(1'b0, 8'h3c, r);
    acc(1'b1, 8'h3c, 32'h0000_ffff);
    acc(1'b1, 8'h38, 32'h0000_0000);
    st_q.push_back(16'h0000);
    ticks(1);
    wait_store();
    acc(1'b0, 8'h38, 32'h0000_0007);
    acc(1'b0, 8'h3c, 32'h0000_0000);
    run_state = 1'b0;
    ticks(2);
    acc(1'b0, 8'h38, 32'h0000_0007);
    complete_run();
  end
endmodule // test_usb_frame_timing_counters
